// >>> logic/pcs_pkg.sv
// constants and types shared by the program counter sequencer
package pcs_pkg;
  localparam int unsigned PCS_ADDR_W = 11;
  localparam int unsigned PCS_PAGE_LSB_W = 6;
  localparam int unsigned PCS_PAGE_MSB_W = 5;
  localparam int unsigned PCS_SPACE_BYTES = 2048;
  localparam logic [10:0] PCS_RESET_ADDR = 11'h000;
  localparam logic [5:0] PCS_PAGE_LAST = 6'h3f;
  localparam logic [10:0] PCS_STEP_SHORT = 11'h001;
  localparam logic [10:0] PCS_STEP_LONG = 11'h002;
  localparam logic [4:0] PCS_PAGE_STEP = 5'h01;
  localparam logic [1:0] PCS_LEN_ZERO = 2'h0;

  typedef enum logic [2:0] {
    PCS_OP_SEQ,
    PCS_OP_LONG_BRANCH,
    PCS_OP_SHORT_BRANCH,
    PCS_OP_CALL,
    PCS_OP_RETURN
  } pcs_op_t;
endpackage

// >>> logic/pcs_next_addr.sv
// combinational next-address calculator for the sequencer
`timescale 1ns/10ps
module pcs_next_addr
  import pcs_pkg::*;
(
  input wire logic [10:0] cur_addr_i,
  input wire pcs_op_t op_i,
  input wire logic [1:0] inst_len_i,
  input wire logic status_flag_i,
  input wire logic [10:0] imm_addr_i,
  input wire logic [10:0] stack_addr_i,
  output logic [10:0] next_addr_o
);
  function automatic logic [10:0] pcs_add(input logic [10:0] a, input logic [10:0] b);
    pcs_add = a + b;
  endfunction

  always_comb
  begin
    next_addr_o = pcs_add(cur_addr_i, {9'h000, inst_len_i}); // [RL2]
    unique case (op_i)
      PCS_OP_SEQ:
      begin
        next_addr_o = pcs_add(cur_addr_i, {9'h000, inst_len_i}); // [RL2]
      end
      PCS_OP_LONG_BRANCH:
      begin
        if (status_flag_i)
          next_addr_o = imm_addr_i; // [RL8] [RL11]
        else
          next_addr_o = pcs_add(cur_addr_i, PCS_STEP_LONG); // [RL8]
      end
      PCS_OP_SHORT_BRANCH:
      begin
        if (!status_flag_i)
          next_addr_o = pcs_add(cur_addr_i, PCS_STEP_SHORT); // [RL7]
        else if (cur_addr_i[PCS_PAGE_LSB_W-1:0] == PCS_PAGE_LAST)
          next_addr_o = {cur_addr_i[10:6] + PCS_PAGE_STEP, imm_addr_i[5:0]}; // [RL6]
        else
          next_addr_o = {cur_addr_i[10:6], imm_addr_i[5:0]}; // [RL5] [RL7]
      end
      PCS_OP_CALL:
      begin
        next_addr_o = imm_addr_i; // [RL9]
      end
      PCS_OP_RETURN:
      begin
        next_addr_o = stack_addr_i; // [RL10]
      end
      default:
      begin
        next_addr_o = cur_addr_i;
      end
    endcase
  end
endmodule

// >>> logic/pcs_sequencer.sv
// program counter sequencer top: holds and advances the fetch address
`timescale 1ns/10ps
// Overview of operation
// RL1 - fetch address lives in an 11-bit binary counter register
// RL2 - ordinary fetch advances counter by instruction byte length
// RL3 - reset forces counter to zero
// RL4 - full 2048-byte space addressed directly, no banking
// RL5 - taken short branch loads only low 6 bits from immediate
// RL6 - taken short branch at page last address bumps upper 5 bits
// RL7 - taken short branch elsewhere keeps upper bits; not taken adds 1
// RL8 - long branch loads immediate if flag set, else adds 2
// RL9 - call loads full counter with immediate target
// RL10 - subroutine or interrupt return reloads counter from stack value
// RL11 - branch decision uses flag left by preceding instruction
module pcs_sequencer
  import pcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic fetch_i,
  input wire pcs_op_t op_i,
  input wire logic [1:0] inst_len_i,
  input wire logic status_flag_i,
  input wire logic [10:0] imm_addr_i,
  input wire logic [10:0] stack_addr_i,
  output logic [10:0] instruction_address_counter_o,
  output logic page_cross_o
);
  typedef struct packed {
    logic [10:0] addr;
    logic page_cross;
  } pcs_state_t;

  pcs_state_t state_r;
  pcs_state_t state_nxt;
  logic [10:0] calc_addr;

  ////////////////////////////////////////////////////////////////////////////
  pcs_next_addr u_next (
    .cur_addr_i(state_r.addr),
    .op_i(op_i),
    .inst_len_i(inst_len_i),
    .status_flag_i(status_flag_i), // sampled as driven by decoder now [RL11]
    .imm_addr_i(imm_addr_i),
    .stack_addr_i(stack_addr_i),
    .next_addr_o(calc_addr)
  );

  // page index of an address; shared by the pulse logic and the checks
  function automatic logic [PCS_PAGE_MSB_W-1:0] pcs_page_of(input logic [PCS_ADDR_W-1:0] addr);
    pcs_page_of = addr[PCS_ADDR_W-1:PCS_PAGE_LSB_W];
  endfunction

  // offset of an address inside its page
  function automatic logic [PCS_PAGE_LSB_W-1:0] pcs_offset_of(input logic [PCS_ADDR_W-1:0] addr);
    pcs_offset_of = addr[PCS_PAGE_LSB_W-1:0];
  endfunction

  always_comb
  begin
    state_nxt = state_r;
    state_nxt.page_cross = 1'b0;
    if (fetch_i)
    begin
      // 11 bits wrap naturally at top of space [RL4]
      state_nxt.addr = calc_addr; // [RL1]
      // one-cycle pulse only, so a slow observer can miss it
      state_nxt.page_cross = (pcs_page_of(state_r.addr) != pcs_page_of(calc_addr));
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_r.addr <= PCS_RESET_ADDR; // [RL3]
      state_r.page_cross <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign instruction_address_counter_o = state_r.addr;
  assign page_cross_o = state_r.page_cross;

  ////////////////////////////////////////////////////////////////////////////
  // named steps for each kind of fetch, split by flag and page offset, plus idle; the checks below other than the two reset checks are built from them
  sequence s_fetch_seq;
    fetch_i && op_i == PCS_OP_SEQ;
  endsequence

  sequence s_fetch_seq_empty;
    fetch_i && op_i == PCS_OP_SEQ && inst_len_i == PCS_LEN_ZERO;
  endsequence

  sequence s_fetch_wrap;
    fetch_i && op_i == PCS_OP_SEQ && state_r.addr == {PCS_ADDR_W{1'b1}} && inst_len_i == 2'h1;
  endsequence

  sequence s_idle;
    !fetch_i;
  endsequence

  sequence s_long_taken;
    fetch_i && op_i == PCS_OP_LONG_BRANCH && status_flag_i;
  endsequence

  sequence s_long_not;
    fetch_i && op_i == PCS_OP_LONG_BRANCH && !status_flag_i;
  endsequence

  sequence s_short_taken;
    fetch_i && op_i == PCS_OP_SHORT_BRANCH && status_flag_i;
  endsequence

  sequence s_short_not;
    fetch_i && op_i == PCS_OP_SHORT_BRANCH && !status_flag_i;
  endsequence

  sequence s_short_taken_last;
    fetch_i && op_i == PCS_OP_SHORT_BRANCH && status_flag_i && pcs_offset_of(state_r.addr) == PCS_PAGE_LAST;
  endsequence

  sequence s_short_taken_mid;
    fetch_i && op_i == PCS_OP_SHORT_BRANCH && status_flag_i && pcs_offset_of(state_r.addr) != PCS_PAGE_LAST;
  endsequence

  sequence s_short_not_last;
    fetch_i && op_i == PCS_OP_SHORT_BRANCH && !status_flag_i && pcs_offset_of(state_r.addr) == PCS_PAGE_LAST;
  endsequence

  sequence s_call;
    fetch_i && op_i == PCS_OP_CALL;
  endsequence

  sequence s_return;
    fetch_i && op_i == PCS_OP_RETURN;
  endsequence

  // reset checks carry no disable, they must hold while reset is applied
  AST_RESET_ZERO: assert property (@(posedge clk_i) srst_i |=> state_r.addr == PCS_RESET_ADDR) // [RL3]
    else $error("counter not zero after reset");

  AST_RESET_CROSS: assert property (@(posedge clk_i) srst_i |=> !page_cross_o) // [RL3]
    else $error("page pulse set after reset");

  AST_SEQ_ADV: assert property (@(posedge clk_i) disable iff (srst_i) // [RL2]
    s_fetch_seq |=> state_r.addr == $past(state_r.addr) + 11'($past(inst_len_i)))
    else $error("sequential advance wrong");

  AST_SEQ_EMPTY: assert property (@(posedge clk_i) disable iff (srst_i) // [RL2]
    s_fetch_seq_empty |=> $stable(state_r.addr))
    else $error("zero length fetch moved counter");

  AST_HOLD: assert property (@(posedge clk_i) disable iff (srst_i) // [RL1]
    s_idle |=> $stable(state_r.addr))
    else $error("counter moved without fetch");

  AST_IDLE_CROSS: assert property (@(posedge clk_i) disable iff (srst_i) // [RL1]
    s_idle |=> !page_cross_o)
    else $error("page pulse without fetch");

  // top of space rolls to zero, no bank register exists
  AST_WRAP: assert property (@(posedge clk_i) disable iff (srst_i) // [RL4]
    s_fetch_wrap |=> state_r.addr == PCS_RESET_ADDR)
    else $error("counter did not wrap over full space");

  AST_WRAP_CROSS: assert property (@(posedge clk_i) disable iff (srst_i) // [RL4]
    s_fetch_wrap |=> page_cross_o)
    else $error("wrap gave no page pulse");

  AST_LONG_TAKEN: assert property (@(posedge clk_i) disable iff (srst_i) // [RL8] [RL11]
    s_long_taken |=> state_r.addr == $past(imm_addr_i))
    else $error("taken long branch target wrong");

  // untaken long branch ignores the length input on purpose
  AST_LONG_NOT: assert property (@(posedge clk_i) disable iff (srst_i) // [RL8] [RL11]
    s_long_not |=> state_r.addr == $past(state_r.addr) + PCS_STEP_LONG)
    else $error("untaken long branch not plus two");

  AST_SHORT_LOW: assert property (@(posedge clk_i) disable iff (srst_i) // [RL5]
    s_short_taken |=> pcs_offset_of(state_r.addr) == pcs_offset_of($past(imm_addr_i)))
    else $error("short branch low bits wrong");

  AST_SHORT_NEXT_PAGE: assert property (@(posedge clk_i) disable iff (srst_i) // [RL6]
    s_short_taken_last |=> pcs_page_of(state_r.addr) == pcs_page_of($past(state_r.addr)) + PCS_PAGE_STEP)
    else $error("short branch at page end did not advance page");

  AST_SHORT_LAST_CROSS: assert property (@(posedge clk_i) disable iff (srst_i) // [RL6]
    s_short_taken_last |=> page_cross_o)
    else $error("page end branch gave no page pulse");

  AST_SHORT_KEEP: assert property (@(posedge clk_i) disable iff (srst_i) // [RL7]
    s_short_taken_mid |=> pcs_page_of(state_r.addr) == pcs_page_of($past(state_r.addr)))
    else $error("short branch changed page");

  AST_SHORT_MID_CROSS: assert property (@(posedge clk_i) disable iff (srst_i) // [RL5] [RL7]
    s_short_taken_mid |=> !page_cross_o)
    else $error("in page branch gave page pulse");

  AST_SHORT_NT: assert property (@(posedge clk_i) disable iff (srst_i) // [RL7]
    s_short_not |=> state_r.addr == $past(state_r.addr) + PCS_STEP_SHORT)
    else $error("untaken short branch not plus one");

  AST_SHORT_NT_LAST_CROSS: assert property (@(posedge clk_i) disable iff (srst_i) // [RL7]
    s_short_not_last |=> page_cross_o)
    else $error("untaken branch at page end gave no page pulse");

  AST_CALL: assert property (@(posedge clk_i) disable iff (srst_i) // [RL9]
    s_call |=> state_r.addr == $past(imm_addr_i))
    else $error("call target not loaded");

  // one path serves both kinds of return
  AST_RET: assert property (@(posedge clk_i) disable iff (srst_i) // [RL10]
    s_return |=> state_r.addr == $past(stack_addr_i))
    else $error("return address not loaded");
endmodule

// >>> verification/tb.sv
// self-checking bench for the program counter sequencer
`timescale 1ns/10ps
module tb;
  import pcs_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic fetch_i = 1'b0;
  pcs_op_t op_i = PCS_OP_SEQ;
  logic [1:0] inst_len_i = 2'h0;
  logic status_flag_i = 1'b0;
  logic [10:0] imm_addr_i = 11'h000;
  logic [10:0] stack_addr_i = 11'h123;
  logic [10:0] instruction_address_counter_o;
  logic page_cross_o;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #25 clk_i = ~clk_i;
  pcs_sequencer dut (.clk_i(clk_i), .srst_i(srst_i), .fetch_i(fetch_i), .op_i(op_i), .inst_len_i(inst_len_i),
    .status_flag_i(status_flag_i), .imm_addr_i(imm_addr_i), .stack_addr_i(stack_addr_i),
    .instruction_address_counter_o(instruction_address_counter_o), .page_cross_o(page_cross_o));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // fetch stays high so fetches run back to back; idle drops it
  task automatic go(input pcs_op_t op, input logic [1:0] len, input logic flag, input logic [10:0] imm);
    fetch_i = 1'b1;
    op_i = op;
    inst_len_i = len;
    status_flag_i = flag;
    imm_addr_i = imm;
    @(negedge clk_i);
  endtask
  task automatic idle();
    fetch_i = 1'b0;
    @(negedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_seq();
    go(PCS_OP_SEQ, 2'h1, 1'b0, 11'h7ff); check("pc", instruction_address_counter_o, 11'h001);
    go(PCS_OP_SEQ, 2'h2, 1'b1, 11'h7ff); check("pc", instruction_address_counter_o, 11'h003);
    go(PCS_OP_SEQ, 2'h0, 1'b0, 11'h000); check("pc", instruction_address_counter_o, 11'h003);
    idle(); check("pc", instruction_address_counter_o, 11'h003);
  endtask
  task automatic t_long();
    go(PCS_OP_LONG_BRANCH, 2'h1, 1'b1, 11'h7fe); check("pc", instruction_address_counter_o, 11'h7fe);
    go(PCS_OP_LONG_BRANCH, 2'h1, 1'b0, 11'h155); check("pc", instruction_address_counter_o, 11'h000);
    go(PCS_OP_LONG_BRANCH, 2'h2, 1'b1, 11'h155); check("pc", instruction_address_counter_o, 11'h155);
    idle();
  endtask
  task automatic t_short();
    go(PCS_OP_CALL, 2'h2, 1'b0, 11'h085); check("pc", instruction_address_counter_o, 11'h085);
    go(PCS_OP_SHORT_BRANCH, 2'h1, 1'b1, 11'h7ff); check("pc", instruction_address_counter_o, 11'h0bf);
    check("cross", {10'h000, page_cross_o}, 11'h000);
    go(PCS_OP_SHORT_BRANCH, 2'h1, 1'b1, 11'h005); check("pc", instruction_address_counter_o, 11'h0c5);
    check("cross", {10'h000, page_cross_o}, 11'h001);
    go(PCS_OP_SHORT_BRANCH, 2'h1, 1'b0, 11'h03f); check("pc", instruction_address_counter_o, 11'h0c6);
    check("cross", {10'h000, page_cross_o}, 11'h000);
    go(PCS_OP_CALL, 2'h2, 1'b1, 11'h7ff); check("pc", instruction_address_counter_o, 11'h7ff);
    go(PCS_OP_SHORT_BRANCH, 2'h1, 1'b1, 11'h00a); check("pc", instruction_address_counter_o, 11'h00a);
    go(PCS_OP_RETURN, 2'h1, 1'b1, 11'h456); check("pc", instruction_address_counter_o, 11'h123);
    idle();
  endtask
  task automatic t_wrap();
    go(PCS_OP_CALL, 2'h1, 1'b0, 11'h7ff); check("pc", instruction_address_counter_o, 11'h7ff);
    go(PCS_OP_SEQ, 2'h1, 1'b0, 11'h000); check("pc", instruction_address_counter_o, 11'h000);
    check("cross", {10'h000, page_cross_o}, 11'h001);
    idle(); check("cross", {10'h000, page_cross_o}, 11'h000);
  endtask
  task automatic t_reset();
    srst_i = 1'b1;
    @(negedge clk_i);
    check("pc", instruction_address_counter_o, 11'h000);
    check("cross", {10'h000, page_cross_o}, 11'h000);
    srst_i = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // bench should finish in well under a hundred cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      errors++;
      test_done();
    end
  end
  initial
  begin
    repeat (12) @(negedge clk_i);
    t_reset();
    t_seq();
    t_long();
    t_short();
    t_wrap();
    go(PCS_OP_SEQ, 2'h2, 1'b0, 11'h000);
    t_reset();
    test_done();
  end
endmodule
